// file: common/lppi_map.svh
`ifndef LPPI_MAP_SVH
`define LPPI_MAP_SVH
// =====================================================
// link clock phases (ck is clk divided by four)
`define LPPI_PH_RISE_LOAD 2'h2
`define LPPI_PH_FALL_LOAD 2'h0
`define LPPI_PH_CK_HI_A   2'h3
`define LPPI_PH_CK_HI_B   2'h0
// =====================================================
// burst and timing counts
`define LPPI_BURST_BEATS  4'h8
`define LPPI_WR_LAT_CK    4'h2
`define LPPI_RD_TIMEOUT   8'h40
`define LPPI_BUF_DEPTH    2
// =====================================================
// reset values
`define LPPI_CKE_RST      1'h0
`define LPPI_CS_N_RST     1'h1
`define LPPI_ODT_RST      1'h0
`endif

// file: common/lppi_pkg.sv
package lppi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_WLAT   = 4'h2,
      ST_WBURST = 4'h4,
      ST_RWAIT  = 4'h8
   } lppi_state_t;

   typedef enum logic [1:0] {
      KIND_NONE  = 2'h0,
      KIND_WRITE = 2'h1,
      KIND_READ  = 2'h2
   } lppi_kind_t;
endpackage

// file: logic/lppi_buf.sv
`timescale 1ns/1ps
module lppi_buf #(
   parameter int W     = 36,
   parameter int DEPTH = 2
) (
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [PW-1:0] next_wr_ptr;
   logic [PW-1:0] next_rd_ptr;
   logic [CW-1:0] next_count;
   logic          push;
   logic          pop;

   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr      <= '0;
         rd_ptr      <= '0;
         count       <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wr_ptr      <= next_wr_ptr;
         rd_ptr      <= next_rd_ptr;
         count       <= next_count;
         in_ready_o  <= (next_count < CW'(DEPTH));
         out_valid_o <= (next_count != '0);
      end
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule

// file: logic/lppi_host.sv
`timescale 1ns/1ps
`include "lppi_map.svh"

// Operation
// R1: ca carries a rise half and a fall half, each stable across its ck edge.
// R2: chip select and clock enable change only for the ck rising edge.
// R3: ck rising edge is true rising while complement falls.
// R4: clock enable low stops device clocks, buffers and drivers.
// R5: clock enable transitions requested by commands enter and leave power saving.
// R6: each command is clock enable, chip select and ca presented together.
// R7: a beat with its mask high is discarded by the device.
// R8: mask travels with write data on both strobe edges.
// R9: mask bit n covers data byte n.
// R10: controller drives the strobe on writes only; device drives it on reads.
// R11: write strobe edges sit in the centre of each data beat.
// R12: strobe n qualifies data byte lane n.
// R13: termination control follows the command's odt request.
// R14: 32-bit data is driven by controller on writes only.
// R15: ca lines are sourced only by the controller.
// R16: every burst is exactly eight beats.
module lppi_host #(
   parameter logic [3:0] WL         = `LPPI_WR_LAT_CK,
   parameter logic [7:0] RD_TIMEOUT = `LPPI_RD_TIMEOUT
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        cmd_valid_i,
   output logic             cmd_ready_o,
   input  wire logic [1:0]  cmd_kind_i,
   input  wire logic        cmd_cke_i,
   input  wire logic        cmd_cs_n_i,
   input  wire logic [9:0]  cmd_ca_rise_i,
   input  wire logic [9:0]  cmd_ca_fall_i,
   input  wire logic        cmd_odt_i,
   input  wire logic        wr_valid_i,
   output logic             wr_ready_o,
   input  wire logic [31:0] wr_data_i,
   input  wire logic [3:0]  wr_mask_i,
   output logic             rd_valid_o,
   output logic [31:0]      rd_data_o,
   output logic             rd_timeout_o,
   output logic             ck_t_o,
   output logic             ck_c_o,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic [9:0]       ca_o,
   output logic             odt_o,
   output logic [3:0]       dm_o,
   input  wire logic [31:0] dq_i,
   output logic [31:0]      dq_o,
   output logic [31:0]      dq_oe_n_o,
   input  wire logic [3:0]  dqs_t_i,
   input  wire logic [3:0]  dqs_c_i,
   output logic [3:0]       dqs_t_o,
   output logic [3:0]       dqs_c_o,
   output logic [3:0]       dqs_oe_n_o
);
   // =====================================================
   // state
   lppi_pkg::lppi_state_t state;
   lppi_pkg::lppi_state_t next_state;
   logic [1:0]  ph;
   logic [1:0]  next_ph;
   logic [3:0]  lat;
   logic [3:0]  next_lat;
   logic [3:0]  beat;
   logic [3:0]  next_beat;
   logic [3:0]  rd_cnt;
   logic [3:0]  next_rd_cnt;
   logic [7:0]  tmo;
   logic [7:0]  next_tmo;
   logic [9:0]  ca_fall;
   logic [9:0]  next_ca_fall;
   logic        next_cmd_ready;
   logic        next_ck_t;
   logic        next_cke;
   logic        next_cs_n;
   logic [9:0]  next_ca;
   logic        next_odt;
   logic [3:0]  next_dm;
   logic [31:0] next_dq;
   logic        next_oe_n;
   logic        next_dqs;
   logic        next_rd_valid;
   logic [31:0] next_rd_data;
   logic        next_rd_tmo;
   logic        accept;
   logic        load_slot;
   logic        buf_valid;
   logic [35:0] buf_data;
   logic [3:0]  lane_edge;
   logic [7:0]  lane_byte [4];

   // =====================================================
   // write data buffer
   lppi_buf #(
      .W     (36),
      .DEPTH (`LPPI_BUF_DEPTH)
   ) u_wbuf (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .in_data_i   ({wr_mask_i, wr_data_i}),
      .out_valid_o (buf_valid),
      .out_ready_i (load_slot),
      .out_data_o  (buf_data)
   );

   assign accept    = cmd_valid_i && cmd_ready_o && (ph == `LPPI_PH_RISE_LOAD);
   assign load_slot = ((ph == `LPPI_PH_FALL_LOAD) || (ph == `LPPI_PH_RISE_LOAD)) &&
                      (((state == lppi_pkg::ST_WBURST) && (beat != `LPPI_BURST_BEATS)) ||
                       ((state == lppi_pkg::ST_WLAT) && (ph == `LPPI_PH_RISE_LOAD) && (lat <= 4'h1)));

   // =====================================================
   // read capture, one strobe per byte lane
   // R12: lane own strobe
   for (genvar l = 0; l < 4; l++) begin : g_lane
      logic       t_s1;
      logic       t_s2;
      logic       c_s1;
      logic       c_s2;
      logic [7:0] b_s1;
      logic [7:0] b_s2;
      logic       lvl_d;
      logic       edge_d;
      logic       edge_dd;
      logic [7:0] cap;
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            t_s1    <= 1'b0;
            t_s2    <= 1'b0;
            c_s1    <= 1'b1;
            c_s2    <= 1'b1;
            b_s1    <= 8'h00;
            b_s2    <= 8'h00;
            lvl_d   <= 1'b0;
            edge_d  <= 1'b0;
            edge_dd <= 1'b0;
            cap     <= 8'h00;
         end else begin
            t_s1    <= dqs_t_i[l];
            t_s2    <= t_s1;
            c_s1    <= dqs_c_i[l];
            c_s2    <= c_s1;
            b_s1    <= dq_i[8*l +: 8];
            b_s2    <= b_s1;
            lvl_d   <= t_s2 & ~c_s2;
            edge_d  <= (t_s2 & ~c_s2) ^ lvl_d;
            edge_dd <= edge_d;
            if (edge_d) begin
               cap <= b_s2;
            end
         end
      end
      assign lane_edge[l] = edge_dd;
      assign lane_byte[l] = cap;
   end

   // =====================================================
   // next-state logic
   always_comb begin
      next_ph       = ph + 2'h1;
      next_state    = state;
      next_lat      = lat;
      next_beat     = beat;
      next_rd_cnt   = rd_cnt;
      next_tmo      = tmo;
      next_ca_fall  = ca_fall;
      next_cke      = cke_o;
      next_cs_n     = cs_n_o;
      next_ca       = ca_o;
      next_odt      = odt_o;
      next_dm       = dm_o;
      next_dq       = dq_o;
      next_rd_valid = 1'b0;
      next_rd_data  = rd_data_o;
      next_rd_tmo   = 1'b0;
      // R1: ck from divider
      next_ck_t     = (ph == `LPPI_PH_CK_HI_A) || (ph == `LPPI_PH_CK_HI_B);
      // R2: sdr on rise
      if (ph == `LPPI_PH_RISE_LOAD) begin
         next_cs_n = 1'b1;
      end
      // R1: fall half
      if (ph == `LPPI_PH_FALL_LOAD) begin
         next_ca = ca_fall;
      end
      // R6: command as one
      if (accept) begin
         next_cs_n    = cmd_cs_n_i;
         // R5: cke transitions requested
         next_cke     = cmd_cke_i;
         // R15: ca output only
         next_ca      = cmd_ca_rise_i;
         next_ca_fall = cmd_ca_fall_i;
         // R13: odt per command
         next_odt     = cmd_odt_i;
      end
      unique case (state)
         lppi_pkg::ST_IDLE: begin
            if (accept && (cmd_kind_i == lppi_pkg::KIND_WRITE)) begin
               next_state = lppi_pkg::ST_WLAT;
               next_lat   = WL;
            end else if (accept && (cmd_kind_i == lppi_pkg::KIND_READ)) begin
               next_state  = lppi_pkg::ST_RWAIT;
               next_rd_cnt = 4'h0;
               next_tmo    = 8'h00;
            end
         end
         lppi_pkg::ST_WLAT: begin
            if (ph == `LPPI_PH_RISE_LOAD) begin
               next_lat = lat - 4'h1;
               if (lat <= 4'h1) begin
                  next_state = lppi_pkg::ST_WBURST;
                  next_beat  = 4'h0;
               end
            end
         end
         lppi_pkg::ST_WBURST: begin
            // R16: eight beats
            if ((ph == `LPPI_PH_RISE_LOAD) && (beat == `LPPI_BURST_BEATS)) begin
               next_state = lppi_pkg::ST_IDLE;
            end
         end
         lppi_pkg::ST_RWAIT: begin
            next_tmo = tmo + 8'h01;
            if (lane_edge[0]) begin
               next_rd_valid = 1'b1;
               next_rd_data  = {lane_byte[3], lane_byte[2], lane_byte[1], lane_byte[0]};
               next_rd_cnt   = rd_cnt + 4'h1;
               if (rd_cnt == `LPPI_BURST_BEATS - 4'h1) begin
                  next_state = lppi_pkg::ST_IDLE;
               end
            end else if (tmo == RD_TIMEOUT) begin
               next_rd_tmo = 1'b1;
               next_state  = lppi_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = lppi_pkg::ST_IDLE;
         end
      endcase
      // entry into the burst loads beat 0 on the same phase
      if (load_slot) begin
         // R8: mask with data
         next_dq   = buf_data[31:0];
         // R7: empty buffer masks beat
         // R9: mask per byte
         next_dm   = buf_valid ? buf_data[35:32] : 4'hf;
         next_beat = next_beat + 4'h1;
      end
      // R10: write strobe ownership
      // R14: dq driven on writes
      next_oe_n      = (next_state != lppi_pkg::ST_WBURST);
      // R11: strobe edges centred
      next_dqs       = (next_state == lppi_pkg::ST_WBURST) && next_ck_t;
      next_cmd_ready = (next_state == lppi_pkg::ST_IDLE) && (next_ph == `LPPI_PH_RISE_LOAD);
   end

   // =====================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state        <= lppi_pkg::ST_IDLE;
         ph           <= 2'h0;
         lat          <= 4'h0;
         beat         <= 4'h0;
         rd_cnt       <= 4'h0;
         tmo          <= 8'h00;
         ca_fall      <= 10'h000;
         cmd_ready_o  <= 1'b0;
         ck_t_o       <= 1'b0;
         ck_c_o       <= 1'b1;
         cke_o        <= `LPPI_CKE_RST;
         cs_n_o       <= `LPPI_CS_N_RST;
         ca_o         <= 10'h000;
         odt_o        <= `LPPI_ODT_RST;
         dm_o         <= 4'h0;
         dq_o         <= 32'h0000_0000;
         dq_oe_n_o    <= 32'hffff_ffff;
         dqs_t_o      <= 4'h0;
         dqs_c_o      <= 4'hf;
         dqs_oe_n_o   <= 4'hf;
         rd_valid_o   <= 1'b0;
         rd_data_o    <= 32'h0000_0000;
         rd_timeout_o <= 1'b0;
      end else begin
         state        <= next_state;
         ph           <= next_ph;
         lat          <= next_lat;
         beat         <= next_beat;
         rd_cnt       <= next_rd_cnt;
         tmo          <= next_tmo;
         ca_fall      <= next_ca_fall;
         cmd_ready_o  <= next_cmd_ready;
         ck_t_o       <= next_ck_t;
         ck_c_o       <= ~next_ck_t;
         cke_o        <= next_cke;
         cs_n_o       <= next_cs_n;
         ca_o         <= next_ca;
         odt_o        <= next_odt;
         dm_o         <= next_dm;
         dq_o         <= next_dq;
         dq_oe_n_o    <= {32{next_oe_n}};
         dqs_t_o      <= {4{next_dqs}};
         dqs_c_o      <= {4{~next_dqs}};
         dqs_oe_n_o   <= {4{next_oe_n}};
         rd_valid_o   <= next_rd_valid;
         rd_data_o    <= next_rd_data;
         rd_timeout_o <= next_rd_tmo;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   logic [3:0] dqs_rises;
   always_ff @(posedge clk_i) begin
      if (srst_i || dqs_oe_n_o[0]) begin
         dqs_rises <= 4'h0;
      end else if (!dqs_t_o[0] && next_dqs) begin
         dqs_rises <= dqs_rises + 4'h1;
      end
   end

   sequence s_accept;
      accept;
   endsequence
   sequence s_cmd_on_pins;
      ##1 (cs_n_o == $past(cmd_cs_n_i)) && (cke_o == $past(cmd_cke_i)) && (ca_o == $past(cmd_ca_rise_i))
      ##2 (ca_o == $past(cmd_ca_fall_i, 3));
   endsequence

   chk_ca_two_halves: assert property ($changed(ca_o) |-> (ph == 2'h3) || (ph == 2'h1)) // R1
      else $error("ca changed on a ck edge");
   chk_sdr_on_rise: assert property (($changed(cs_n_o) || $changed(cke_o)) |-> ph == 2'h3) // R2
      else $error("cs or cke changed off rising half");
   chk_cmd_as_one: assert property (s_accept |-> s_cmd_on_pins) // R6
      else $error("command fields not driven together");
   chk_odt_follows: assert property (s_accept |=> odt_o == $past(cmd_odt_i)) // R13
      else $error("odt not taken from command");
   chk_empty_masked: assert property (load_slot && !buf_valid |=> dm_o == 4'hf) // R7
      else $error("missing beat not masked");
   chk_mask_with_data: assert property ($changed(dm_o) |-> (ph == 2'h3) || (ph == 2'h1)) // R8
      else $error("mask moved off data timing");
   chk_strobe_centred: assert property ($changed(dqs_t_o[0]) && !dqs_oe_n_o[0] |-> $stable(dq_o)) // R11
      else $error("strobe edge on data change");
   chk_read_no_drive: assert property (state == lppi_pkg::ST_RWAIT |-> &dqs_oe_n_o && &dq_oe_n_o) // R10
      else $error("controller drives bus during read");
   chk_dq_whole_bus: assert property ((dq_oe_n_o == 32'h0) || (dq_oe_n_o == 32'hffff_ffff)) // R14
      else $error("data bus partly driven");
   chk_burst_eight: assert property ($rose(dqs_oe_n_o[0]) |-> $past(dqs_rises) == 4'h4) // R16
      else $error("write burst not eight beats");
endmodule

// file: dv/lppi_dev_model.sv
`timescale 1ns/1ps
module lppi_dev_model #(
   parameter logic [2:0] WR_OP = 3'h4,
   parameter logic [2:0] RD_OP = 3'h5
) (
   input  wire logic        clk_i,
   input  wire logic        ck_t_i,
   input  wire logic        ck_c_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic [9:0]  ca_i,
   input  wire logic        odt_i,
   input  wire logic [3:0]  dm_i,
   input  wire logic [31:0] dq_i,
   input  wire logic [3:0]  dqs_t_i,
   input  wire logic [3:0]  dqs_oe_n_i,
   input  wire logic        mute_i,
   input  wire logic [5:0]  lat_i,
   input  wire logic [2:0]  mem_sel_i,
   output logic [31:0]      mem_o,
   output logic [31:0]      dq_o,
   output logic             dq_drv_o,
   output logic [3:0]       dqs_t_o,
   output logic             dqs_drv_o,
   output logic [9:0]       cmd_r_o,
   output logic [9:0]       cmd_f_o,
   output logic [7:0]       cmd_cnt_o,
   output logic             pd_o,
   output logic             odt_o,
   output logic [3:0]       wr_beats_o
);
   logic [31:0] mem [8];
   logic [3:0]  bcnt [4];
   logic [3:0]  prev_s;
   logic        sel;
   logic        cke_q;
   event        rd_ev;
   assign mem_o = mem[mem_sel_i];
   assign wr_beats_o = bcnt[0];
   initial begin
      for (int k = 0; k < 8; k++) begin
         mem[k] = 32'hffffffff;
      end
      bcnt = '{4'h0, 4'h0, 4'h0, 4'h0};
      {cmd_cnt_o, pd_o, cke_q, sel, odt_o, dq_drv_o, dqs_drv_o} = '0;
      {cmd_r_o, cmd_f_o, dq_o, dqs_t_o, prev_s} = '0;
   end
   // ===============================
   // command capture
   // rise half on positive crossing
   always begin
      @(posedge ck_t_i);
      #1;
      if (ck_c_i === 1'b0) begin
         // cke gates command select (odt is sampled regardless), edges move power saving
         if (cke_q && !cke_i) pd_o = 1'b1;
         if (!cke_q && cke_i) pd_o = 1'b0;
         cke_q = cke_i;
         sel = cke_i && !cs_n_i;
         odt_o = odt_i;
         if (sel) cmd_r_o = ca_i;
      end
   end
   always begin
      @(negedge ck_t_i);
      #1;
      if (sel && ck_c_i === 1'b1) begin
         cmd_f_o = ca_i;
         cmd_cnt_o = cmd_cnt_o + 8'h1;
         if (cmd_r_o[2:0] == WR_OP) bcnt = '{4'h0, 4'h0, 4'h0, 4'h0};
         if (cmd_r_o[2:0] == RD_OP && !mute_i) -> rd_ev;
      end
   end
   // ===============================
   // write capture
   // lane n byte on each lane n strobe edge
   always @(dqs_t_i) begin
      for (int n = 0; n < 4; n++) begin
         if (dqs_t_i[n] !== prev_s[n] && dqs_oe_n_i[n] === 1'b0 && bcnt[n] < 4'h8) begin
            if (dm_i[n] === 1'b0) mem[bcnt[n][2:0]][8*n +: 8] = dq_i[8*n +: 8];
            bcnt[n] = bcnt[n] + 4'h1;
         end
      end
      prev_s = dqs_t_i;
   end
   // ===============================
   // read answer
   // eight beats, strobe edge with data
   always begin
      @(rd_ev);
      repeat (lat_i) @(posedge clk_i);
      #1;
      dq_drv_o = 1'b1;
      dqs_drv_o = 1'b1;
      for (int k = 0; k < 8; k++) begin
         dq_o = 32'hd0c0b0a0 + 32'h01010101 * k;
         dqs_t_o = ~dqs_t_o;
         repeat (4) @(posedge clk_i);
         #1;
      end
      dq_drv_o = 1'b0;
      repeat (2) @(posedge clk_i);
      dqs_drv_o = 1'b0;
   end
endmodule

// file: dv/lppi_host_tb.sv
`timescale 1ns/1ps
module lppi_host_tb;
   localparam int DLY = 1;
   logic        clk_i, srst_i, cmd_valid_i, cmd_ready_o, cmd_cke_i, cmd_cs_n_i, cmd_odt_i, wr_valid_i;
   logic        wr_ready_o, rd_valid_o, rd_timeout_o, ck_t_o, ck_c_o, cke_o, cs_n_o, odt_o;
   logic        mute, dev_dq_drv, dev_dqs_drv, dev_pd, dev_odt;
   logic [1:0]  cmd_kind_i;
   logic [2:0]  mem_sel;
   logic [3:0]  wr_mask_i, dm_o, dqs_t_o, dqs_c_o, dqs_oe_n_o, dqs_w, dev_dqs, dev_beats;
   logic [5:0]  lat;
   logic [7:0]  dev_cnt;
   logic [9:0]  cmd_ca_rise_i, cmd_ca_fall_i, ca_o, dev_r, dev_f;
   logic [31:0] wr_data_i, rd_data_o, dq_o, dq_oe_n_o, dq_w, dev_dq, float_pat, mem_w;
   int          errors = 0, checked = 0, cycles = 0;

   lppi_host dut_u (.clk_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .cmd_kind_i, .cmd_cke_i, .cmd_cs_n_i,
      .cmd_ca_rise_i, .cmd_ca_fall_i, .cmd_odt_i, .wr_valid_i, .wr_ready_o, .wr_data_i, .wr_mask_i,
      .rd_valid_o, .rd_data_o, .rd_timeout_o, .ck_t_o, .ck_c_o, .cke_o, .cs_n_o, .ca_o, .odt_o, .dm_o,
      .dq_i(dq_w), .dq_o, .dq_oe_n_o, .dqs_t_i(dqs_w), .dqs_c_i(~dqs_w), .dqs_t_o, .dqs_c_o, .dqs_oe_n_o);

   lppi_dev_model dev_u (.clk_i, .ck_t_i(ck_t_o), .ck_c_i(ck_c_o), .cke_i(cke_o), .cs_n_i(cs_n_o),
      .ca_i(ca_o), .odt_i(odt_o), .dm_i(dm_o), .dq_i(dq_w), .dqs_t_i(dqs_w), .dqs_oe_n_i(dqs_oe_n_o),
      .mute_i(mute), .lat_i(lat), .mem_sel_i(mem_sel), .mem_o(mem_w), .dq_o(dev_dq), .dq_drv_o(dev_dq_drv),
      .dqs_t_o(dev_dqs), .dqs_drv_o(dev_dqs_drv), .cmd_r_o(dev_r), .cmd_f_o(dev_f), .cmd_cnt_o(dev_cnt),
      .pd_o(dev_pd), .odt_o(dev_odt), .wr_beats_o(dev_beats));

   // ===============================
   // wire resolution: floating data keeps moving, strobe terminated low
   assign dq_w = (dq_oe_n_o[0] === 1'b0) ? dq_o : dev_dq_drv ? dev_dq : float_pat;
   assign dqs_w = (dqs_oe_n_o[0] === 1'b0) ? dqs_t_o : dev_dqs_drv ? dev_dqs : 4'h0;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      float_pat <= ~float_pat;
      cycles++;
      if (cycles == 5000) begin
         errors++;
         tally_and_finish;
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] wdat(input int k);
      return 32'h30201000 + 32'h01010101 * k;
   endfunction

   function automatic logic [3:0] wmsk(input int k);
      return (k == 7) ? 4'hf : (k < 4) ? 4'h1 << k : 4'h0;
   endfunction

   task automatic cmd(input logic [1:0] k, input logic e, input logic s, input logic [9:0] r, input logic o);
      int n;
      @(posedge clk_i);
      #DLY;
      {cmd_kind_i, cmd_cke_i, cmd_cs_n_i, cmd_ca_rise_i, cmd_ca_fall_i, cmd_odt_i} = {k, e, s, r, ~r, o};
      cmd_valid_i = 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cmd_ready_o !== 1'b1 && n < 300);
      #DLY;
      cmd_valid_i = 1'b0;
   endtask

   task automatic push(input int first, input int cnt);
      int n;
      @(posedge clk_i);
      #DLY;
      for (int k = first; k < first + cnt; k++) begin
         wr_data_i = wdat(k);
         wr_mask_i = wmsk(k);
         wr_valid_i = 1'b1;
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (wr_ready_o !== 1'b1 && n < 300);
         #DLY;
      end
      wr_valid_i = 1'b0;
   endtask

   task automatic t_cmd;
      cmd(lppi_pkg::KIND_NONE, 1'b1, 1'b0, 10'h3c1, 1'b1);
      repeat (8) @(posedge clk_i);
      chk("ca_rise", dev_r, 10'h3c1);
      chk("ca_fall", dev_f, 10'h03e);
      chk("odt", dev_odt, 1'b1);
      chk("cmd_cnt", dev_cnt, 8'h1);
      cmd(lppi_pkg::KIND_NONE, 1'b0, 1'b0, 10'h000, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("pd_entry", dev_pd, 1'b1);
      chk("cmd_cnt", dev_cnt, 8'h1);
      cmd(2'h3, 1'b1, 1'b1, 10'h000, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("pd_exit", dev_pd, 1'b0);
      chk("odt", dev_odt, 1'b0);
   endtask

   task automatic t_write(input logic fill);
      logic [31:0] e;
      logic [3:0]  m;
      int          n;
      if (fill) begin
         push(0, 2);
         @(posedge clk_i);
         #DLY;
         chk("wr_ready_full", wr_ready_o, 1'b0);
      end
      fork
         cmd(lppi_pkg::KIND_WRITE, 1'b1, 1'b0, 10'h004, 1'b1);
         if (fill) push(2, 6);
      join
      repeat (12) @(posedge clk_i);
      n = 0;
      while (dev_beats !== 4'h8 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      repeat (8) @(posedge clk_i);
      chk("beats", dev_beats, 4'h8);
      chk("dq_released", dq_oe_n_o, 32'hffffffff);
      for (int k = 0; k < 8; k++) begin
         mem_sel = k[2:0];
         #DLY;
         m = wmsk(k);
         e = wdat(k);
         for (int b = 0; b < 4; b++) begin
            if (m[b]) e[8*b +: 8] = 8'hff;
         end
         chk("mem", mem_w, e);
      end
   endtask

   task automatic t_read(input logic [5:0] l, input logic mt);
      int v;
      int t;
      lat = l;
      mute = mt;
      cmd(lppi_pkg::KIND_READ, 1'b1, 1'b0, 10'h005, 1'b0);
      v = 0;
      t = 0;
      for (int c = 0; c < 200; c++) begin
         @(posedge clk_i);
         #DLY;
         if (rd_timeout_o === 1'b1) t++;
         if (rd_valid_o === 1'b1) begin
            chk("rd_data", rd_data_o, 32'hd0c0b0a0 + 32'h01010101 * v);
            v++;
         end
      end
      chk("rd_beats", v, mt ? 0 : 8);
      chk("rd_timeout", t, mt ? 1 : 0);
      mute = 1'b0;
   endtask

   initial begin
      {clk_i, srst_i, cmd_valid_i, cmd_cke_i, cmd_cs_n_i, cmd_odt_i, wr_valid_i, mute} = 8'h4c;
      {cmd_kind_i, cmd_ca_rise_i, cmd_ca_fall_i, wr_data_i, wr_mask_i} = '0;
      {mem_sel, lat} = 9'h002;
      float_pat = 32'h5aa5c33c;
      repeat (4) @(posedge clk_i);
      #DLY;
      chk("cs_n_rst", cs_n_o, 1'b1);
      chk("cke_rst", cke_o, 1'b0);
      chk("ck_c_rst", ck_c_o, 1'b1);
      chk("dq_oe_rst", dq_oe_n_o, 32'hffffffff);
      chk("dqs_oe_rst", dqs_oe_n_o, 4'hf);
      chk("dqs_c_rst", dqs_c_o, 4'hf);
      srst_i = 1'b0;
      $display("test reset done");
      t_cmd();
      $display("test command done");
      t_write(1'b1);
      $display("test write done");
      t_write(1'b0);
      $display("test empty write done");
      t_read(6'h02, 1'b0);
      t_read(6'h18, 1'b0);
      $display("test read done");
      t_read(6'h02, 1'b1);
      $display("test read timeout done");
      tally_and_finish;
   end
endmodule
